// ===== verilog/hpsr_pkg.sv
package hpsr_pkg;
   // Target select codes on access_target_select
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_DATA_AUTO = 2'h1;
   localparam logic [1:0] SEL_ADDR = 2'h2;
   localparam logic [1:0] SEL_DATA = 2'h3;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 32;
   // Data leads ready by 2P-4 ns: round up to whole cycles
   localparam int CLK_PERIOD_NS = 20;
   localparam int DATA_LEAD_NS = 2 * CLK_PERIOD_NS - 4;
   localparam int DATA_LEAD_CYC =
      (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] LEAD_LAST = 2'(DATA_LEAD_CYC - 1);
   localparam logic [1:0] LEAD_ZERO = 2'h0;
   localparam logic [1:0] LEAD_STEP = 2'h1;

   typedef struct packed {
      logic [1:0] target;
      logic read_not_write;
      logic second_half;
   } hpsr_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_LEAD = 2'b11,
      ST_DONE = 2'b10
   } hpsr_state_t;
endpackage

// ===== verilog/hpsr_fifo.sv
`timescale 1ns/1ps
module hpsr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== verilog/hpsr_top.sv
`timescale 1ns/1ps
// Function
// - Internal strobe is NOT(strobe a XOR strobe b) OR chip select, low.
// - Ready output reads low whenever chip select is high.
// - Ready is high at chip select fall while earlier work is unfinished.
// - First-half data read requests a fetch and holds ready high till a lead after load.
// - After second half of data write or auto read, ready rises on release.
// - Other accesses leave ready low and never show busy.
// - Control and address register traffic never changes ready.
// - Data bus is driven only on reads, from strobe fall to strobe rise.
// - Read data is on the bus a whole lead before ready goes low.
module hpsr_top
   import hpsr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Host pins
   input wire logic host_chip_select_n,
   input wire logic data_strobe_a_n,
   input wire logic data_strobe_b_n,
   input wire logic address_strobe_n,
   input wire logic [1:0] access_target_select,
   input wire logic host_read_not_write,
   input wire logic halfword_select,
   output logic host_ready_n,
   input wire logic [15:0] host_data_bus_in,
   output logic [15:0] host_data_bus_out,
   output logic host_data_bus_oe,
   // Fetch request to the internal address generator
   output logic fetch_req,
   input wire logic fetch_load,
   input wire logic [31:0] fetch_data,
   // Completed data-register writes, buffered
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [31:0] wr_data,
   // Selects of the last access, for register decode
   output hpsr_pkg::hpsr_sel_t last_sel
);
   import hpsr_pkg::*;

   // Three-stage pin synchronisers, two-stage for the data bus; first stage feeds only the second
   logic [2:0] cs_s, sa_s, sb_s, as_s;
   hpsr_sel_t sel_s1, sel_s2, sel_s3;
   logic [15:0] hd_s1, hd_s2;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cs_s <= 3'h7;
         sa_s <= 3'h7;
         sb_s <= 3'h7;
         as_s <= 3'h7;
         sel_s1 <= '0;
         sel_s2 <= '0;
         sel_s3 <= '0;
      end else begin
         cs_s <= {cs_s[1:0], host_chip_select_n};
         sa_s <= {sa_s[1:0], data_strobe_a_n};
         sb_s <= {sb_s[1:0], data_strobe_b_n};
         as_s <= {as_s[1:0], address_strobe_n};
         sel_s1 <= '{access_target_select, host_read_not_write,
                     halfword_select};
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
      end
   end

   always_ff @(posedge sys_clk) begin
      hd_s1 <= host_data_bus_in;
      hd_s2 <= hd_s1;
   end

   // Filtered levels change only when stages two and three agree
   logic cs_f, sa_f, sb_f, as_f, strobe_f, as_f_d;
   wire cs_new = (cs_s[1] == cs_s[2]) ? cs_s[1] : cs_f;
   wire sa_new = (sa_s[1] == sa_s[2]) ? sa_s[1] : sa_f;
   wire sb_new = (sb_s[1] == sb_s[2]) ? sb_s[1] : sb_f;
   wire as_new = (as_s[1] == as_s[2]) ? as_s[1] : as_f;
   wire strobe_new = ~(sa_new ^ sb_new) | cs_new;
   wire strobe_fall = strobe_f && !strobe_new;
   wire strobe_rise = !strobe_f && strobe_new;
   wire as_fall = as_f_d && !as_f;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cs_f <= 1'b1;
         sa_f <= 1'b1;
         sb_f <= 1'b1;
         as_f <= 1'b1;
         as_f_d <= 1'b1;
         strobe_f <= 1'b1;
      end else begin
         cs_f <= cs_new;
         sa_f <= sa_new;
         sb_f <= sb_new;
         as_f <= as_new;
         as_f_d <= as_f;
         strobe_f <= strobe_new;
      end
   end

   // Selects: captured on address strobe fall when used, else strobe fall
   logic as_taken;
   hpsr_sel_t sel;
   wire hpsr_sel_t sel_now = as_taken ? last_sel : sel_s3;
   wire is_data = sel_now.target == SEL_DATA ||
                  sel_now.target == SEL_DATA_AUTO;
   wire is_rd_first = is_data && sel_now.read_not_write &&
                      !sel_now.second_half;
   wire is_busy_2nd = sel_now.second_half && (
                      (is_data && !sel_now.read_not_write) ||
                      (sel_now.target == SEL_DATA_AUTO &&
                       sel_now.read_not_write));

   hpsr_state_t state;
   hpsr_state_t next_state;
   logic [1:0] lead_cnt;
   logic [31:0] rd_word;
   logic [15:0] wr_low, wr_high;
   logic busy, pending, fetched;
   logic fifo_in_ready;

   // Busy work: one transfer completing inside the device
   wire work_done = state == ST_DONE &&
                    (pending ? fifo_in_ready : fetched);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (strobe_fall && is_rd_first) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (fetch_load) begin
               next_state = ST_LEAD;
            end
         end
         ST_LEAD: begin
            if (lead_cnt == LEAD_LAST) begin
               next_state = ST_IDLE;
            end
         end
         ST_DONE: begin
            if (work_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (state == ST_IDLE && strobe_rise && is_busy_2nd) begin
         next_state = ST_DONE;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         lead_cnt <= LEAD_ZERO;
         as_taken <= 1'b0;
         last_sel <= '0;
         rd_word <= WORD_ZERO;
         wr_low <= HALF_ZERO;
         wr_high <= HALF_ZERO;
         pending <= 1'b0;
         fetched <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         lead_cnt <= (state == ST_LEAD) ? lead_cnt + LEAD_STEP : LEAD_ZERO;
         if (as_fall) begin
            last_sel <= sel_s3;
            as_taken <= 1'b1;
         end else if (strobe_fall && !as_taken) begin
            last_sel <= sel_s3;
         end
         if (strobe_rise) begin
            as_taken <= 1'b0;
         end
         if (fetch_load) begin
            rd_word <= fetch_data;
         end
         // Second half completes the word; first half is held
         if (strobe_rise && is_data && !sel_now.read_not_write) begin
            if (sel_now.second_half) begin
               pending <= 1'b1;
               // Host may move the bus while the FIFO stalls
               wr_high <= hd_s2;
            end else begin
               wr_low <= hd_s2;
            end
         end else if (work_done) begin
            pending <= 1'b0;
         end
         fetched <= (state == ST_DONE && !pending) ? 1'b1 : 1'b0;
         busy <= next_state != ST_IDLE;
      end
   end

   // Auto read prefetch is modelled as two cycles of internal work in ST_DONE
   assign sel = sel_now;
   assign fetch_req = state == ST_IDLE && next_state == ST_WAIT;

   // Control and address traffic never reaches busy
   assign host_ready_n = !cs_f && busy;

   // Bus driven for reads while strobe is low
   wire rd_active = !strobe_f && sel.read_not_write;
   assign host_data_bus_oe = rd_active;
   assign host_data_bus_out = sel.second_half ? rd_word[31:16]
                                              : rd_word[15:0];

   hpsr_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(state == ST_DONE && pending),
      .in_ready(fifo_in_ready),
      .in_data({wr_high, wr_low}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );

endmodule

// ===== verif/hpsr_assertions.sv
`timescale 1ns/1ps
module hpsr_assertions
   import hpsr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Host pins
   input wire logic host_chip_select_n,
   input wire logic data_strobe_a_n,
   input wire logic data_strobe_b_n,
   input wire logic [1:0] access_target_select,
   input wire logic host_read_not_write,
   input wire logic halfword_select,
   input wire logic host_ready_n,
   input wire logic [15:0] host_data_bus_out,
   input wire logic host_data_bus_oe,
   // Fetch side
   input wire logic fetch_req
);
   import hpsr_pkg::*;
   wire stb_n = ~(data_strobe_a_n ^ data_strobe_b_n) | host_chip_select_n;
   wire dat = access_target_select[0];
   wire rd = host_read_not_write;
   wire tail = halfword_select & dat &
      (~rd | (access_target_select == SEL_DATA_AUTO));
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_cs_gate: assert property (host_chip_select_n [*6]
      |-> !host_ready_n)
      else $error("ready busy while deselected");
   chk_fetch_pulse: assert property (fetch_req |=> !fetch_req)
      else $error("fetch request longer than one cycle");
   chk_fetch_cause: assert property (fetch_req
      |-> dat && rd && !halfword_select && !stb_n)
      else $error("fetch request without first-half data read");
   chk_fetch_busy: assert property (fetch_req |=> host_ready_n)
      else $error("ready not busy after fetch request");
   chk_lead_data: assert property ($fell(host_ready_n)
      && host_data_bus_oe
      |-> $past(host_data_bus_out, 2) == host_data_bus_out)
      else $error("read data not held two cycles before ready");
   chk_oe_read: assert property (host_data_bus_oe |-> rd)
      else $error("bus driven on a write");
   chk_oe_idle: assert property (stb_n [*6] |-> !host_data_bus_oe)
      else $error("bus driven with strobe released");
   chk_reg_quiet: assert property (!stb_n && !dat
      && !host_ready_n |=> !host_ready_n)
      else $error("register access made ready busy");
   chk_tail_busy: assert property ($rose(stb_n) && tail
      |-> ##[1:8] host_ready_n)
      else $error("no busy after completing half");
   cov_fetch: cover property (fetch_req);
   cov_tail: cover property ($rose(host_ready_n) && stb_n);
   cov_read: cover property ($fell(host_ready_n) && host_data_bus_oe);
endmodule

bind hpsr_top hpsr_assertions i_hpsr_assertions (.sys_clk, .nrst,
   .host_chip_select_n, .data_strobe_a_n, .data_strobe_b_n,
   .access_target_select, .host_read_not_write, .halfword_select,
   .host_ready_n, .host_data_bus_out, .host_data_bus_oe, .fetch_req);

// ===== verif/hpsr_fetch_model.sv
`timescale 1ns/1ps
module hpsr_fetch_model (
   // Clock
   input wire logic sys_clk,
   // Request, and what to answer with
   input wire logic fetch_req,
   input wire logic [3:0] delay,
   input wire logic [31:0] word,
   output logic fetch_load,
   output logic [31:0] fetch_data
);
   initial begin
      fetch_load = 1'b0;
      fetch_data = 32'h0000_0000;
   end
   // Data is inverted outside the load cycle so a late sample fails
   always @(posedge sys_clk) begin
      if (fetch_req === 1'b1) begin
         repeat (delay + 1) @(negedge sys_clk);
         fetch_load = 1'b1;
         fetch_data = word;
         @(negedge sys_clk);
         fetch_load = 1'b0;
         fetch_data = ~word;
      end
   end
endmodule

// ===== verif/hpsr_top_tb_top.sv
`timescale 1ns/1ps
module hpsr_top_tb_top;
   import hpsr_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, host_chip_select_n = 1'b1;
   logic data_strobe_a_n = 1'b1, data_strobe_b_n = 1'b1;
   logic address_strobe_n = 1'b1, host_read_not_write = 1'b0;
   logic halfword_select = 1'b0, wr_ready = 1'b0, hold_wr = 1'b0;
   logic [1:0] access_target_select = 2'h0, t;
   logic [15:0] host_data_bus_in = 16'h0000, q0, q1;
   logic [3:0] delay = 4'h0;
   logic [31:0] word = 32'h0000_0000, w;
   logic host_ready_n, host_data_bus_oe, fetch_req, fetch_load, wr_valid;
   logic r;
   logic [15:0] host_data_bus_out;
   logic [31:0] fetch_data, wr_data;
   hpsr_sel_t last_sel;
   logic [31:0] exp_q[$];
   int seed = 32'h6685_4818, n_errors = 0, checked = 0, cyc = 0;
   always #10 sys_clk = ~sys_clk;
   hpsr_top i_hpsr_top (.sys_clk, .nrst, .host_chip_select_n,
      .data_strobe_a_n, .data_strobe_b_n, .address_strobe_n,
      .access_target_select, .host_read_not_write, .halfword_select,
      .host_ready_n, .host_data_bus_in, .host_data_bus_out,
      .host_data_bus_oe, .fetch_req, .fetch_load, .fetch_data,
      .wr_valid, .wr_ready, .wr_data, .last_sel);
   hpsr_fetch_model i_hpsr_fetch_model (.sys_clk, .fetch_req, .delay,
      .word, .fetch_load, .fetch_data);
   task automatic check(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // A second half that leaves work behind inside the device
   function automatic logic tail_busy(input logic [1:0] tt,
                                      input logic rr, hh);
      return hh && (rr ? tt == SEL_DATA_AUTO
                       : (tt == SEL_DATA || tt == SEL_DATA_AUTO));
   endfunction
   task automatic wait_low();
      for (int n = 0; n < 400 && host_ready_n !== 1'b0; n++)
         @(negedge sys_clk);
      check(host_ready_n, 1'b0, "ready stuck busy");
   endtask
   // One half-word access as a host would run it
   task automatic acc(input logic [1:0] tt, input logic rr, hh,
                      input logic [15:0] d, output logic [15:0] q);
      logic pk;
      pk = 1'($random(seed));
      @(negedge sys_clk);
      {access_target_select, host_read_not_write, halfword_select} =
         {tt, rr, hh};
      host_data_bus_in = rr ? ~host_data_bus_in : d;
      host_chip_select_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      wait_low();
      address_strobe_n = ~pk;
      @(negedge sys_clk);
      {data_strobe_a_n, data_strobe_b_n} = pk ? 2'b01 : 2'b10;
      @(negedge sys_clk);
      address_strobe_n = 1'b1;
      repeat (12) @(negedge sys_clk);
      wait_low();
      q = host_data_bus_out;
      check(host_data_bus_oe, rr, "bus drive");
      check(last_sel, {tt, rr, hh}, "selects");
      {data_strobe_a_n, data_strobe_b_n} = 2'b11;
      // Release reaches the filtered strobe on the fourth edge
      repeat (4) @(negedge sys_clk);
      check(host_ready_n, tail_busy(tt, rr, hh), "tail busy");
      check(host_data_bus_oe, 1'b0, "bus release");
      repeat (4) @(negedge sys_clk);
      host_chip_select_n = 1'b1;
   endtask
   // Far side stalls at random
   always @(negedge sys_clk)
      wr_ready = hold_wr ? 1'b0 : 1'($random(seed));
   always @(posedge sys_clk)
      if (wr_valid && wr_ready)
         check(wr_data, exp_q.size() ? exp_q.pop_front() : 'x, "wr");
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      nrst = 1'b1;
      for (int i = 0; i < 40; i++) begin
         {t, r} = (i < 8) ? 3'(i) : 3'($random(seed));
         w = $random(seed);
         word = w;
         delay = 4'($random(seed));
         if (t[0] && !r) exp_q.push_back(w);
         acc(t, r, 1'b0, w[15:0], q0);
         acc(t, r, 1'b1, w[31:16], q1);
         if (t[0] && r) check({q1, q0}, w, "rd");
      end
      repeat (60) @(negedge sys_clk);
      hold_wr = 1'b1;
      for (int i = 0; i < 9; i++) begin
         w = $random(seed);
         exp_q.push_back(w);
         acc(SEL_DATA, 1'b0, 1'b0, w[15:0], q0);
         acc(SEL_DATA, 1'b0, 1'b1, w[31:16], q1);
      end
      // Deselect long enough for the gate to take effect first
      repeat (8) @(negedge sys_clk);
      host_chip_select_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      check(host_ready_n, 1'b1, "busy at select");
      hold_wr = 1'b0;
      wait_low();
      host_chip_select_n = 1'b1;
      repeat (80) @(negedge sys_clk);
      check(exp_q.size(), 0, "drained");
      results();
   end
endmodule
